// ### core/vplc_lock_ctrl.sv
// Purpose: Genlock lock control of the video clock loop, with APB registers
// Assumes: href_pulse is a one-cycle strobe synchronous to pclk
// Notes: Summary of operation below
`timescale 1ns/1ps
`include "vplc_params.svh"
module vplc_lock_ctrl #(
	parameter int LINE_NS_0 = 63556,
	parameter int LINE_NS_1 = 64000,
	parameter int LINE_NS_2 = 29630,
	parameter int LINE_NS_3 = 44444
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic href_pulse,
	output logic video_lock,
	output logic lock_lost,
	output logic crash_active,
	output logic coast,
	output logic [5:0] bw_cap,
	output logic [5:0] bw_res,
	output logic [1:0] out_std
);
	localparam int LINE_CYC_0 = LINE_NS_0 / `VPLC_CLK_NS;
	localparam int LINE_CYC_1 = LINE_NS_1 / `VPLC_CLK_NS;
	localparam int LINE_CYC_2 = LINE_NS_2 / `VPLC_CLK_NS;
	localparam int LINE_CYC_3 = LINE_NS_3 / `VPLC_CLK_NS;
	// Refuse line periods the 16-bit timer cannot hold
	if (LINE_CYC_0 >= 65000 || LINE_CYC_1 >= 65000 || LINE_CYC_2 >= 65000 || LINE_CYC_3 >= 65000 ||
		LINE_CYC_0 < 64 || LINE_CYC_1 < 64 || LINE_CYC_2 < 64 || LINE_CYC_3 < 64) begin : g_bad_line
		$error("vplc_lock_ctrl: line period out of range");
	end
	// Default field set of an output standard
	function automatic vplc_pkg::vplc_defaults_type vplc_defaults(input logic [1:0] std);
		case (std)
			2'h0: vplc_defaults = `VPLC_DEF_STD0;
			2'h1: vplc_defaults = `VPLC_DEF_STD1;
			2'h2: vplc_defaults = `VPLC_DEF_STD2;
			default: vplc_defaults = `VPLC_DEF_STD3;
		endcase
	endfunction
	// Expected line period in cycles of a standard
	function automatic logic [15:0] vplc_line(input logic [1:0] std);
		case (std)
			2'h0: vplc_line = 16'(LINE_CYC_0);
			2'h1: vplc_line = 16'(LINE_CYC_1);
			2'h2: vplc_line = 16'(LINE_CYC_2);
			default: vplc_line = 16'(LINE_CYC_3);
		endcase
	endfunction
	logic [7:0] crash_r;
	logic [4:0] thr_r;
	logic [2:0] run_r;
	logic [5:0] cap_r, res_r;
	logic [1:0] std_r;
	logic [31:0] prdata_r;
	logic [15:0] tmr_r;
	logic [9:0] crash_left_r;
	logic [2:0] miss_r;
	logic [5:0] good_r, bad_r;
	logic coast_r, lock_lost_r;
	vplc_pkg::vplc_state_type state_r;
	vplc_pkg::vplc_defaults_type def;
	logic [9:0] idx;
	logic [15:0] exp_p;
	logic [9:0] crash_len;
	logic wr, std_chg, mapped, in_time, missing, h_evt, good, tolerated, disturb;
	// Bus decode
	assign idx = paddr[11:2];
	assign wr = psel && penable && pwrite;
	assign std_chg = wr && idx == `VPLC_IDX_STD && pwdata[1:0] != std_r;
	assign mapped = idx == `VPLC_IDX_TIMING || idx == `VPLC_IDX_RESERVED_SLOT_AFTER_LOCK_CONFIG || idx == `VPLC_IDX_CAP ||
		idx == `VPLC_IDX_RES || idx == `VPLC_IDX_STD || idx == `VPLC_IDX_STATUS;
	assign pready = 1'b1; // Zero wait states
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_r;
	assign def = vplc_defaults(pwdata[1:0]);
	// Standard select register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			std_r <= `VPLC_STD_RST;
		end else if (std_chg) begin
			std_r <= pwdata[1:0];
		end
	end

	// Loop fields, reloaded on a standard change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{crash_r, thr_r, run_r, cap_r, res_r} <= `VPLC_DEF_STD0;
		end else if (std_chg) begin
			{crash_r, thr_r, run_r, cap_r, res_r} <= def;
		end else if (wr && idx == `VPLC_IDX_TIMING) begin
			crash_r <= pwdata[`VPLC_CRASH_MSB:`VPLC_CRASH_LSB];
			thr_r <= pwdata[`VPLC_THR_MSB:`VPLC_THR_LSB];
			run_r <= pwdata[`VPLC_RUN_MSB:`VPLC_RUN_LSB];
		end else if (wr && idx == `VPLC_IDX_CAP) begin
			cap_r <= pwdata[`VPLC_BW_MSB:0]; // Upper bits dropped
		end else if (wr && idx == `VPLC_IDX_RES) begin
			res_r <= pwdata[`VPLC_BW_MSB:0];
		end
	end
	// Read data, captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (psel && !penable) begin
			case (idx)
				`VPLC_IDX_TIMING: prdata_r <= {16'h0000, crash_r, thr_r, run_r};
				`VPLC_IDX_CAP: prdata_r <= {26'h000_0000, cap_r};
				`VPLC_IDX_RES: prdata_r <= {26'h000_0000, res_r};
				`VPLC_IDX_STD: prdata_r <= {30'h0000_0000, std_r};
				`VPLC_IDX_STATUS: prdata_r <= {28'h000_0000, crash_active, coast_r, lock_lost_r, video_lock};
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// Reference line classification
	assign exp_p = vplc_line(std_r);
	assign in_time = (tmr_r + 16'h0001 + `VPLC_LINE_TOL_CYC >= exp_p) &&
		(tmr_r + 16'h0001 <= exp_p + `VPLC_LINE_TOL_CYC);
	assign missing = !href_pulse && tmr_r + 16'h0001 >= exp_p + `VPLC_LINE_TOL_CYC;
	assign h_evt = href_pulse || missing;
	assign good = href_pulse && in_time;
	assign tolerated = h_evt && !good && miss_r < run_r;
	assign disturb = h_evt && !good && !tolerated;
	assign crash_len = ({2'b00, crash_r} << `VPLC_CRASH_MUL_SH) + `VPLC_CRASH_ADD;

	// Line timer, restarted by real or stand-in pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr_r <= 16'h0000;
		end else if (h_evt || std_chg) begin
			tmr_r <= 16'h0000;
		end else begin
			tmr_r <= tmr_r + 16'h0001;
		end
	end

	// Missing-pulse tolerance and coast flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			miss_r <= 3'h0;
			coast_r <= 1'b0;
		end else if (good || std_chg) begin
			miss_r <= 3'h0;
			coast_r <= 1'b0;
		end else if (h_evt) begin
			if (miss_r != 3'h7) begin
				miss_r <= miss_r + 3'h1;
			end
			coast_r <= tolerated;
		end
	end

	// Crash then tracking; the threshold plays no part here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= vplc_pkg::VPLC_ST_CRASH;
			crash_left_r <= 10'h000;
		end else if (std_chg) begin
			state_r <= vplc_pkg::VPLC_ST_CRASH;
			crash_left_r <= 10'h000;
		end else begin
			case (state_r)
				vplc_pkg::VPLC_ST_CRASH: begin
					if (h_evt) begin
						if (crash_left_r + 10'h001 >= crash_len) begin
							state_r <= vplc_pkg::VPLC_ST_TRACK;
							crash_left_r <= 10'h000;
						end else begin
							crash_left_r <= crash_left_r + 10'h001;
						end
					end
				end
				vplc_pkg::VPLC_ST_TRACK: state_r <= vplc_pkg::VPLC_ST_TRACK;
				default: state_r <= vplc_pkg::VPLC_ST_CRASH;
			endcase
		end
	end

	// Good and bad line runs, and the loss-of-lock indicator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			good_r <= 6'h00;
			bad_r <= 6'h00;
			lock_lost_r <= 1'b1;
		end else if (std_chg || state_r != vplc_pkg::VPLC_ST_TRACK) begin
			good_r <= 6'h00;
			bad_r <= 6'h00;
			lock_lost_r <= 1'b1;
		end else if (good) begin
			bad_r <= 6'h00;
			if (good_r != 6'h3F) begin
				good_r <= good_r + 6'h01;
			end
			if (good_r >= {1'b0, thr_r}) begin
				lock_lost_r <= 1'b0;
			end
		end else if (disturb) begin
			good_r <= 6'h00;
			if (bad_r != 6'h3F) begin
				bad_r <= bad_r + 6'h01;
			end
			if (bad_r >= {1'b0, thr_r}) begin
				lock_lost_r <= 1'b1;
			end
		end
	end
	// Output pins
	assign video_lock = state_r == vplc_pkg::VPLC_ST_TRACK && !lock_lost_r;
	assign lock_lost = lock_lost_r;
	assign crash_active = state_r == vplc_pkg::VPLC_ST_CRASH;
	assign coast = coast_r;
	assign bw_cap = cap_r;
	assign bw_res = res_r;
	assign out_std = std_r;
	// Checks
	property p_crash_exit;
		@(posedge pclk) disable iff (!presetn)
		crash_active && h_evt && !std_chg && crash_left_r == crash_len - 10'h001 |=> !crash_active;
	endproperty
	a_crash_exit: assert property (p_crash_exit) else $error("crash did not end on time");
	property p_crash_hold;
		@(posedge pclk) disable iff (!presetn)
		crash_active && h_evt && crash_left_r + 10'h001 < crash_len |=> crash_active;
	endproperty
	a_crash_hold: assert property (p_crash_hold) else $error("crash ended early");
	property p_lost_set;
		@(posedge pclk) disable iff (!presetn)
		!crash_active && !std_chg && disturb && bad_r >= {1'b0, thr_r} |=> lock_lost;
	endproperty
	a_lost_set: assert property (p_lost_set) else $error("loss of lock not raised");
	property p_lost_fall;
		@(posedge pclk) disable iff (!presetn)
		$fell(lock_lost) |-> $past(good) && $past(good_r) >= {1'b0, $past(thr_r)};
	endproperty
	a_lost_fall: assert property (p_lost_fall) else $error("lock reported too soon");
	property p_coast;
		@(posedge pclk) disable iff (!presetn)
		!std_chg && h_evt && !good && miss_r < run_r |=> coast && bad_r == $past(bad_r);
	endproperty
	a_coast: assert property (p_coast) else $error("tolerated pulse counted as error");
	property p_one_miss;
		@(posedge pclk) disable iff (!presetn)
		run_r != 3'h0 && miss_r == 3'h0 && missing && video_lock && !std_chg |=> video_lock;
	endproperty
	a_one_miss: assert property (p_one_miss) else $error("lock dropped on one missing pulse");
	property p_no_tol;
		@(posedge pclk) disable iff (!presetn)
		run_r == 3'h0 && h_evt && !good |-> disturb ##1 !coast;
	endproperty
	a_no_tol: assert property (p_no_tol) else $error("disturbance not seen at once");
	property p_std_load;
		@(posedge pclk) disable iff (!presetn)
		std_chg |=> {crash_r, thr_r, run_r, cap_r, res_r} == vplc_defaults(out_std) && crash_active;
	endproperty
	a_std_load: assert property (p_std_load) else $error("defaults not loaded");
	property p_lock_bit;
		@(posedge pclk) disable iff (!presetn)
		video_lock |-> !crash_active && !lock_lost && ($past(video_lock) || $past(good));
	endproperty
	a_lock_bit: assert property (p_lock_bit) else $error("lock bit while not tracking");
	property p_lost_rise;
		@(posedge pclk) disable iff (!presetn)
		$rose(lock_lost) |-> $past(disturb) || $past(std_chg) || crash_active;
	endproperty
	a_lost_rise: assert property (p_lost_rise) else $error("loss of lock without cause");
	c_crash_done: cover property (@(posedge pclk) disable iff (!presetn) $fell(crash_active));
	c_locked: cover property (@(posedge pclk) disable iff (!presetn) $rose(video_lock));
	c_coast: cover property (@(posedge pclk) disable iff (!presetn) $rose(coast) && video_lock);
	c_std: cover property (@(posedge pclk) disable iff (!presetn) std_chg);
endmodule

// ### inc/vplc_params.svh
// Purpose: Constants of the video loop lock control block
// Assumes: APB word registers, byte address is four times the index
// Notes: Default sets pack crash, threshold, tolerance, cap and res fields
`ifndef VPLC_PARAMS_SVH
`define VPLC_PARAMS_SVH
// Register indices
`define VPLC_IDX_TIMING 10'h024
`define VPLC_IDX_RESERVED_SLOT_AFTER_LOCK_CONFIG 10'h025
`define VPLC_IDX_CAP 10'h026
`define VPLC_IDX_RES 10'h027
`define VPLC_IDX_STD 10'h030
`define VPLC_IDX_STATUS 10'h031
// Timing and bandwidth register field positions
`define VPLC_CRASH_MSB 15
`define VPLC_CRASH_LSB 8
`define VPLC_THR_MSB 7
`define VPLC_THR_LSB 3
`define VPLC_RUN_MSB 2
`define VPLC_RUN_LSB 0
`define VPLC_BW_MSB 5
// Crash period is crash field times four plus one
`define VPLC_CRASH_MUL_SH 2
`define VPLC_CRASH_ADD 10'h001
// Standard select reset value and per-standard defaults
`define VPLC_STD_RST 2'h0
`define VPLC_DEF_STD0 {8'h10, 5'h04, 3'h1, 6'h0A, 6'h20}
`define VPLC_DEF_STD1 {8'h20, 5'h08, 3'h2, 6'h0C, 6'h24}
`define VPLC_DEF_STD2 {8'h08, 5'h02, 3'h1, 6'h0A, 6'h2A}
`define VPLC_DEF_STD3 {8'h30, 5'h10, 3'h3, 6'h10, 6'h28}
// Clock period and line timing
`define VPLC_CLK_NS 10
`define VPLC_LINE_TOL_CYC 16'h0010
`endif

// ### inc/vplc_pkg.sv
// Purpose: Types of the video loop lock control block
// Assumes: Field widths as in the timing and bandwidth registers
// Notes: None
package vplc_pkg;
	typedef struct packed {
		logic [7:0] crash;
		logic [4:0] thr;
		logic [2:0] run;
		logic [5:0] cap;
		logic [5:0] res;
	} vplc_defaults_type;
	typedef enum logic [1:0] {
		VPLC_ST_CRASH = 2'b01,
		VPLC_ST_TRACK = 2'b10
	} vplc_state_type;
endpackage

// ### verif/tb_top.sv
// Purpose: Self-checking bench of the video loop lock control block
// Assumes: Line period shortened to 200 cycles
// Notes: Register rows first, then crash, lock and tolerance cases
`timescale 1ns/1ps
module tb_top;
	localparam int P = 200;
	typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] e;} vplc_row_type;
	typedef struct {logic [31:0] t; logic [2:0] s; logic l; logic c;} vplc_case_type;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, href_pulse, video_lock, lock_lost, crash_active, coast, err;
	logic [5:0] bw_cap, bw_res;
	logic [1:0] out_std;
	logic src_en = 1'h0, skip_go = 1'h0, mon_clr = 1'h0, saw_l, saw_c, saw_d;
	logic [2:0] skip_n = 3'h0;
	int n_mismatch = 0, samples_checked = 0, n_crash = 0, n_wait = 0, k;
	vplc_row_type rows [20] = '{'{1'h0, 12'h0C4, 32'h0, 32'hA}, '{1'h0, 12'h090, 32'h0, 32'h1021},
		'{1'h0, 12'h098, 32'h0, 32'hA}, '{1'h0, 12'h09C, 32'h0, 32'h20}, '{1'h0, 12'h094, 32'h0, 32'h0},
		'{1'h0, 12'h0C0, 32'h0, 32'h0}, '{1'h1, 12'h0C0, 32'h2, 32'h0}, '{1'h0, 12'h090, 32'h0, 32'h0811},
		'{1'h0, 12'h098, 32'h0, 32'hA}, '{1'h0, 12'h09C, 32'h0, 32'h2A}, '{1'h1, 12'h0C0, 32'h1, 32'h0},
		'{1'h0, 12'h090, 32'h0, 32'h2042}, '{1'h0, 12'h098, 32'h0, 32'hC}, '{1'h0, 12'h09C, 32'h0, 32'h24},
		'{1'h1, 12'h09C, 32'h2A, 32'h0}, '{1'h1, 12'h098, 32'hF, 32'h0},
		'{1'h0, 12'h098, 32'h0, 32'hF}, '{1'h0, 12'h09C, 32'h0, 32'h2A},
		'{1'h1, 12'h0C4, 32'hFF, 32'h0}, '{1'h0, 12'h0C4, 32'h0, 32'hA}};
	vplc_case_type cases [3] = '{'{32'h0201, 3'h1, 1'h0, 1'h1}, '{32'h0200, 3'h1, 1'h1, 1'h0},
		'{32'h0203, 3'h2, 1'h0, 1'h1}};

	vplc_lock_ctrl #(.LINE_NS_0(2000), .LINE_NS_1(2000), .LINE_NS_2(2000), .LINE_NS_3(2000)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .href_pulse(href_pulse),
		.video_lock(video_lock), .lock_lost(lock_lost), .crash_active(crash_active), .coast(coast),
		.bw_cap(bw_cap), .bw_res(bw_res), .out_std(out_std));
	vplc_href_src #(.PERIOD(P)) src_u (.pclk(pclk), .presetn(presetn), .en(src_en), .skip_go(skip_go),
		.skip_n(skip_n), .href_pulse(href_pulse));

	// Clock
	always #5 pclk = ~pclk;
	// Crash pulse count, lines until lock report, flag history
	always @(posedge pclk) begin
		if (href_pulse === 1'h1 && crash_active === 1'h1)
			n_crash <= n_crash + 1;
		if (href_pulse === 1'h1 && crash_active === 1'h0 && video_lock === 1'h0)
			n_wait <= n_wait + 1;
		saw_l <= mon_clr ? 1'h0 : (saw_l | (lock_lost === 1'h1));
		saw_c <= mon_clr ? 1'h0 : (saw_c | (coast === 1'h1));
		saw_d <= mon_clr ? 1'h0 : (saw_d | (video_lock !== 1'h1));
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// APB transfer, called just after a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic wait_lock(input int n);
		k = 0;
		while (video_lock !== 1'h1 && k < n) begin
			k++;
			@(posedge pclk);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (60000) @(posedge pclk);
		n_mismatch++;
		finish_test;
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) chk(q, rows[i].e, "register read");
		end
		chk({20'h0, bw_cap, bw_res}, {20'h0, 6'hF, 6'h2A}, "bandwidth outputs");
		chk({30'h0, out_std}, 32'h1, "standard output");
		apb(1'h0, 12'h100, 32'h0);
		chk({err, q[30:0]}, 32'h80000000, "unmapped read");
		$display("test registers done");
		apb(1'h1, 12'h0C0, 32'h0);
		apb(1'h1, 12'h090, 32'h0211);
		n_crash = 0;
		n_wait = 0;
		src_en <= 1'h1;
		wait_lock(20 * P);
		chk(n_crash, 32'h9, "crash periods");
		chk(n_wait, 32'h3, "lines until lock reported");
		chk({crash_active, lock_lost, video_lock}, 3'h1, "lock after crash");
		$display("test crash done");
		foreach (cases[i]) begin
			apb(1'h1, 12'h090, cases[i].t);
			repeat (2 * P) @(posedge pclk);
			mon_clr <= 1'h1;
			skip_n <= cases[i].s;
			skip_go <= 1'h1;
			@(posedge pclk);
			mon_clr <= 1'h0;
			skip_go <= 1'h0;
			repeat ((cases[i].s + 3) * P) @(posedge pclk);
			chk(saw_l, cases[i].l, "lock lost seen");
			chk(saw_c, cases[i].c, "coast seen");
			chk(saw_d, cases[i].l, "lock dropped");
			wait_lock(6 * P);
			chk(video_lock, 1'h1, "relock");
			$display("test tolerance %0d done", i);
		end
		// Higher threshold: same crash length, later lock report
		while (href_pulse !== 1'h1)
			@(posedge pclk);
		apb(1'h1, 12'h0C0, 32'h2);
		apb(1'h1, 12'h090, 32'h0221);
		n_crash = 0;
		n_wait = 0;
		wait_lock(20 * P);
		chk(n_crash, 32'h9, "crash periods at high threshold");
		chk(n_wait, 32'h5, "lines until lock at high threshold");
		$display("test threshold done");
		// Reset in mid-run
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		chk({crash_active, coast, lock_lost, video_lock, out_std, bw_cap, bw_res}, {4'hA, 2'h0, 6'hA, 6'h20},
			"outputs in reset");
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, 12'h090, 32'h0);
		chk(q, 32'h1021, "timing after reset");
		$display("test reset done");
		finish_test;
	end
endmodule

// ### verif/vplc_href_src.sv
// Purpose: Reference horizontal pulse source for the lock control bench
// Assumes: One-cycle strobe, PERIOD cycles per line
// Notes: A skipped slot adds 16 cycles so the next pulse falls one period after the missing-line point
`timescale 1ns/1ps
module vplc_href_src #(
	parameter int PERIOD = 200
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic en,
	input wire logic skip_go,
	input wire logic [2:0] skip_n,
	output logic href_pulse
);
	int cnt;
	logic [2:0] left_r;
	// Line timer with commanded pulse drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			left_r <= 3'h0;
			href_pulse <= 1'h0;
		end else begin
			href_pulse <= 1'h0;
			if (skip_go)
				left_r <= skip_n;
			if (!en)
				cnt <= 0;
			else if (cnt < PERIOD - 1)
				cnt <= cnt + 1;
			else if (left_r != 3'h0) begin
				left_r <= left_r - 3'h1;
				cnt <= -16;
			end else begin
				href_pulse <= 1'h1;
				cnt <= 0;
			end
		end
	end
endmodule
